/* aig_defines.vh */
// Purpose: Shared constants of the accelerometer event and FIFO status block.
// Assumes: Included by bare name from every design file of the block.
// Notes: Offsets are byte addresses on the device register port.
//
// Notes on behaviour
// R01: Threshold status is 1 when stored samples reach or pass the programmed level.
// R02: Overrun status is 1 exactly while the FIFO is completely filled.
// R03: Empty status is 1 while no sample is stored, else 0.
// R04: Current stored sample count appears in a five-bit level field, read-only.
// R05: Each generator combines enabled events by OR or AND; select resets to 0.
// R06: Six-direction mode bit, reset 0, makes enables pick direction recognition.
// R07: Six enable bits per generator gate high and low events; reset 0.
// R08: Status holds an active bit, 1 once events were generated; reset 0.
// R09: Status holds six event flags for X, Y, Z high and low; reset 0.
// R10: Generator one has three eight-bit thresholds, per axis, reset zero.
// R11: Generator two has one shared eight-bit threshold, reset zero.
// R12: Each generator has a wait enable on its duration counter, reset 0.
// R13: Each generator holds a seven-bit duration beside its wait bit, reset zero.
// R14: Status registers are read-only; configuration, threshold and duration are read-write.
// R15: Generator two configuration has the same layout and meaning as generator one.
// R16: With latch set, the request holds until the host reads that status register.
// R17: Duration counter resets when inactive if reset-mode is 0, else decrements.
// R18: Generator one event drives the trigger for trigger-dependent FIFO modes.
// R19: FIFO threshold level is a five-bit control field resetting to zero.
// R20: High is above threshold, low below; recognised after duration samples persist.
// R21: Active bit and output follow combined enabled events, updated once per sample.
`ifndef AIG_DEFINES_VH
`define AIG_DEFINES_VH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define AIG_ADDR_CTRL7      8'h26
`define AIG_ADDR_FIFO_CTRL  8'h2E
`define AIG_ADDR_FIFO_STAT  8'h2F
`define AIG_ADDR_G1_CFG     8'h30
`define AIG_ADDR_G1_STAT    8'h31
`define AIG_ADDR_G1_THX     8'h32
`define AIG_ADDR_G1_THY     8'h33
`define AIG_ADDR_G1_THZ     8'h34
`define AIG_ADDR_G1_DUR     8'h35
`define AIG_ADDR_G2_CFG     8'h36
`define AIG_ADDR_G2_STAT    8'h37
`define AIG_ADDR_G2_THS     8'h38
`define AIG_ADDR_G2_DUR     8'h39

// ----------------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------------
`define AIG_CFG_AOI         7
`define AIG_CFG_SIX         6
`define AIG_DUR_WAIT        7
`define AIG_CTRL7_DCRM2     5
`define AIG_CTRL7_DCRM1     4
`define AIG_CTRL7_LIR2      3
`define AIG_CTRL7_LIR1      2
`define AIG_STAT_ACTIVE     6
`define AIG_FST_LEVEL_BIT   7
`define AIG_FST_FULL_BIT    6
`define AIG_FST_EMPTY_BIT   5
`define AIG_RST_BYTE        8'h00
`define AIG_RST_STAT        7'h00
`define AIG_RST_CNT         7'h00
`define AIG_THR_LSB         7

`endif

/* aig_gen.v */
// Purpose: One accelerometer interrupt generator with duration and latch logic.
// Assumes: sample_valid is a one-cycle pulse per output data sample.
// Notes: Samples are signed; thresholds compare against scaled magnitudes.
`timescale 1ns/10ps
`default_nettype none
`include "aig_defines.vh"

module aig_gen #(
  parameter SW = 16,
  parameter TW = 8,
  parameter DW = 7
) (
  // Clock and reset.
  input  wire              ref_clk,
  input  wire              reset,
  // Sample stream.
  input  wire              sample_valid,
  input  wire [3*SW-1:0]   samples,
  // Configuration.
  input  wire [3*TW-1:0]   thresholds,
  input  wire [7:0]        cfg,
  input  wire [DW-1:0]     event_length,
  input  wire              hold_off_enable,
  input  wire              latch_request,
  input  wire              counter_reset_select,
  input  wire              status_read,
  // Status.
  output reg  [6:0]        status_q
);

  // --------------------------------------------------------------------------
  // Axis comparison
  // --------------------------------------------------------------------------
  // Saturating scaled magnitude; full-scale negative would otherwise wrap to 0.
  function [TW-1:0] scaled_mag;
    input [SW-1:0] s;
    reg   [SW-1:0] m;
    begin
      m = s[SW-1] ? (~s + {{(SW-1){1'b0}}, 1'b1}) : s;
      if (m[SW-1]) begin
        scaled_mag = {TW{1'b1}};
      end else begin
        scaled_mag = m[TW-1+`AIG_THR_LSB:`AIG_THR_LSB];
      end
    end
  endfunction

  wire [5:0] raw_evt;
  genvar a;
  generate
    for (a = 0; a < 3; a = a + 1) begin : g_axis
      wire [SW-1:0] s   = samples[a*SW +: SW];
      wire [TW-1:0] thr = thresholds[a*TW +: TW];
      wire [TW-1:0] m   = scaled_mag(s);
      // Six-direction mode turns the pair into positive and negative tilt.
      assign raw_evt[2*a+1] = cfg[`AIG_CFG_SIX] ? (!s[SW-1] && m > thr)
                                                : (m > thr);           // see R06 see R20
      assign raw_evt[2*a]   = cfg[`AIG_CFG_SIX] ? (s[SW-1] && m > thr)
                                                : (m < thr);           // see R06 see R20
    end
  endgenerate

  // --------------------------------------------------------------------------
  // Event combination
  // --------------------------------------------------------------------------
  // Only enabled events count; AND with nothing enabled never fires.
  wire [5:0] hit  = raw_evt & cfg[5:0];                                // see R07
  wire       cond = cfg[`AIG_CFG_AOI] ? ((hit == cfg[5:0]) && (|cfg[5:0]))
                                      : (|hit);                        // see R05

  // --------------------------------------------------------------------------
  // Duration counter
  // --------------------------------------------------------------------------
  reg  [DW-1:0] cnt_q;
  reg  [DW-1:0] cnt_d;
  reg           act_q;
  reg           act_d;

  // Entry needs event_length+1 samples of the condition; with wait on, exit
  // also needs event_length+1 samples of its absence.
  always @* begin
    cnt_d = cnt_q;
    act_d = act_q;
    if (cond) begin
      if (act_q) begin
        cnt_d = `AIG_RST_CNT;
      end else if (cnt_q >= event_length) begin
        act_d = 1'b1;                                                  // see R20
        cnt_d = `AIG_RST_CNT;
      end else begin
        cnt_d = cnt_q + {{(DW-1){1'b0}}, 1'b1};
      end
    end else if (act_q) begin
      if (!hold_off_enable || cnt_q >= event_length) begin             // see R12
        act_d = 1'b0;
        cnt_d = `AIG_RST_CNT;
      end else begin
        cnt_d = cnt_q + {{(DW-1){1'b0}}, 1'b1};
      end
    end else if (counter_reset_select) begin
      if (cnt_q != `AIG_RST_CNT) begin
        cnt_d = cnt_q - {{(DW-1){1'b0}}, 1'b1};                        // see R17
      end
    end else begin
      cnt_d = `AIG_RST_CNT;                                            // see R17
    end
  end

  // --------------------------------------------------------------------------
  // Status register
  // --------------------------------------------------------------------------
  wire [6:0] new_stat = act_d ? {1'b1, hit} : `AIG_RST_STAT;

  // A latched flag set on a sample in the same cycle as the read survives.
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      cnt_q    <= `AIG_RST_CNT;
      act_q    <= 1'b0;
      status_q <= `AIG_RST_STAT;                                       // see R08 see R09
    end else if (sample_valid) begin
      cnt_q <= cnt_d;
      act_q <= act_d;
      if (latch_request) begin
        status_q <= (status_read ? `AIG_RST_STAT : status_q) | new_stat; // see R16
      end else begin
        status_q <= new_stat;                                          // see R21
      end
    end else if (status_read && latch_request) begin
      status_q <= `AIG_RST_STAT;                                       // see R16
    end
  end

endmodule // aig_gen

`default_nettype wire

/* aig_status_top.v */
// Purpose: Register file, FIFO status and two interrupt generators.
// Assumes: Host accesses arrive as synchronous read and write strobes.
// Notes: Read data appears one cycle after the read strobe.
`timescale 1ns/10ps
`default_nettype none
`include "aig_defines.vh"

module aig_status_top #(
  parameter SW = 16,
  parameter TW = 8,
  parameter DW = 7,
  parameter CW = 6
) (
  // Clock and reset.
  input  wire            ref_clk,
  input  wire            reset,
  // Register port.
  input  wire [7:0]      reg_addr,
  input  wire            reg_wr,
  input  wire [7:0]      reg_wdata,
  input  wire            reg_rd,
  output reg  [7:0]      reg_rdata_q,
  output reg             reg_rvalid_q,
  // Sample stream at the output data rate.
  input  wire            sample_valid,
  input  wire [SW-1:0]   x_sample,
  input  wire [SW-1:0]   y_sample,
  input  wire [SW-1:0]   z_sample,
  // FIFO occupancy from the sample store.
  input  wire [CW-1:0]   fifo_count,
  input  wire            fifo_full,
  // FIFO control towards the sample store.
  output reg  [2:0]      fifo_mode_q,
  output reg  [4:0]      fifo_level_q,
  output reg             fifo_trigger_q,
  // Interrupt requests.
  output reg             int1_q,
  output reg             int2_q
);

  // --------------------------------------------------------------------------
  // Address decode
  // --------------------------------------------------------------------------
  // Used only by the status-read clears; the write path and the read mux decode with case.
  function hit_addr;
    input [7:0] addr;
    input [7:0] target;
    begin
      hit_addr = (addr == target);
    end
  endfunction

  wire rd_g1_stat = reg_rd && hit_addr(reg_addr, `AIG_ADDR_G1_STAT);
  wire rd_g2_stat = reg_rd && hit_addr(reg_addr, `AIG_ADDR_G2_STAT);

  // --------------------------------------------------------------------------
  // Writable registers
  // --------------------------------------------------------------------------
  reg [7:0] ctrl7_q;
  reg [7:0] fifo_ctrl_q;
  reg [7:0] g1_cfg_q;
  reg [7:0] g1_thx_q;
  reg [7:0] g1_thy_q;
  reg [7:0] g1_thz_q;
  reg [7:0] g1_dur_q;
  reg [7:0] g2_cfg_q;
  reg [7:0] g2_ths_q;
  reg [7:0] g2_dur_q;

  // Status offsets have no write branch, so host writes there are dropped.
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      ctrl7_q     <= `AIG_RST_BYTE;
      fifo_ctrl_q <= `AIG_RST_BYTE;                                    // see R19
      g1_cfg_q    <= `AIG_RST_BYTE;                                    // see R05 see R06 see R07
      g1_thx_q    <= `AIG_RST_BYTE;                                    // see R10
      g1_thy_q    <= `AIG_RST_BYTE;
      g1_thz_q    <= `AIG_RST_BYTE;
      g1_dur_q    <= `AIG_RST_BYTE;                                    // see R12 see R13
      g2_cfg_q    <= `AIG_RST_BYTE;                                    // see R15
      g2_ths_q    <= `AIG_RST_BYTE;                                    // see R11
      g2_dur_q    <= `AIG_RST_BYTE;
    end else if (reg_wr) begin
      case (reg_addr)
        `AIG_ADDR_CTRL7: begin
          ctrl7_q <= reg_wdata;
        end
        `AIG_ADDR_FIFO_CTRL: begin
          fifo_ctrl_q <= reg_wdata;
        end
        `AIG_ADDR_G1_CFG: begin
          g1_cfg_q <= reg_wdata;                                       // see R14
        end
        `AIG_ADDR_G1_THX: begin
          g1_thx_q <= reg_wdata;
        end
        `AIG_ADDR_G1_THY: begin
          g1_thy_q <= reg_wdata;
        end
        `AIG_ADDR_G1_THZ: begin
          g1_thz_q <= reg_wdata;
        end
        `AIG_ADDR_G1_DUR: begin
          g1_dur_q <= reg_wdata;
        end
        `AIG_ADDR_G2_CFG: begin
          g2_cfg_q <= reg_wdata;
        end
        `AIG_ADDR_G2_THS: begin
          g2_ths_q <= reg_wdata;
        end
        `AIG_ADDR_G2_DUR: begin
          g2_dur_q <= reg_wdata;
        end
        default: begin
          ctrl7_q <= ctrl7_q;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Interrupt generators
  // --------------------------------------------------------------------------
  wire [3*SW-1:0] samples = {z_sample, y_sample, x_sample};
  wire [6:0]      g1_stat;
  wire [6:0]      g2_stat;

  // Generator one uses one threshold per axis.
  aig_gen #(
    .SW (SW),
    .TW (TW),
    .DW (DW)
  ) u_gen1 (
    .ref_clk              (ref_clk),
    .reset                (reset),
    .sample_valid         (sample_valid),
    .samples              (samples),
    .thresholds           ({g1_thz_q, g1_thy_q, g1_thx_q}),            // see R10
    .cfg                  (g1_cfg_q),
    .event_length         (g1_dur_q[DW-1:0]),                          // see R13
    .hold_off_enable      (g1_dur_q[`AIG_DUR_WAIT]),                   // see R12
    .latch_request        (ctrl7_q[`AIG_CTRL7_LIR1]),
    .counter_reset_select (ctrl7_q[`AIG_CTRL7_DCRM1]),
    .status_read          (rd_g1_stat),                                // see R16
    .status_q             (g1_stat)
  );

  // Generator two shares one threshold across all axes.
  aig_gen #(
    .SW (SW),
    .TW (TW),
    .DW (DW)
  ) u_gen2 (
    .ref_clk              (ref_clk),
    .reset                (reset),
    .sample_valid         (sample_valid),
    .samples              (samples),
    .thresholds           ({g2_ths_q, g2_ths_q, g2_ths_q}),            // see R11
    .cfg                  (g2_cfg_q),                                  // see R15
    .event_length         (g2_dur_q[DW-1:0]),
    .hold_off_enable      (g2_dur_q[`AIG_DUR_WAIT]),
    .latch_request        (ctrl7_q[`AIG_CTRL7_LIR2]),
    .counter_reset_select (ctrl7_q[`AIG_CTRL7_DCRM2]),
    .status_read          (rd_g2_stat),
    .status_q             (g2_stat)
  );

  // --------------------------------------------------------------------------
  // FIFO status
  // --------------------------------------------------------------------------
  // The level field is five bits; a full store of 32 shows as full with
  // level 0, so software should look at the full flag first.
  wire [4:0] fifo_fill_level    = fifo_count[4:0];                     // see R04
  wire       fifo_level_reached = fifo_count >= {{(CW-5){1'b0}}, fifo_ctrl_q[4:0]}; // see R01 see R19
  wire       fifo_full_flag     = fifo_full;                           // see R02
  wire       fifo_empty_flag    = (fifo_count == {CW{1'b0}});          // see R03
  wire [7:0] fifo_status = {fifo_level_reached, fifo_full_flag, fifo_empty_flag,
                            fifo_fill_level};

  // --------------------------------------------------------------------------
  // Read path
  // --------------------------------------------------------------------------
  reg [7:0] rd_mux;

  // Unmapped offsets read as zero; generator status bit 7 is reserved and reads zero.
  always @* begin
    case (reg_addr)
      `AIG_ADDR_CTRL7: begin
        rd_mux = ctrl7_q;
      end
      `AIG_ADDR_FIFO_CTRL: begin
        rd_mux = fifo_ctrl_q;
      end
      `AIG_ADDR_FIFO_STAT: begin
        rd_mux = fifo_status;                                          // see R14
      end
      `AIG_ADDR_G1_CFG: begin
        rd_mux = g1_cfg_q;
      end
      `AIG_ADDR_G1_STAT: begin
        rd_mux = {1'b0, g1_stat};                                      // see R08 see R09
      end
      `AIG_ADDR_G1_THX: begin
        rd_mux = g1_thx_q;
      end
      `AIG_ADDR_G1_THY: begin
        rd_mux = g1_thy_q;
      end
      `AIG_ADDR_G1_THZ: begin
        rd_mux = g1_thz_q;
      end
      `AIG_ADDR_G1_DUR: begin
        rd_mux = g1_dur_q;
      end
      `AIG_ADDR_G2_CFG: begin
        rd_mux = g2_cfg_q;
      end
      `AIG_ADDR_G2_STAT: begin
        rd_mux = {1'b0, g2_stat};
      end
      `AIG_ADDR_G2_THS: begin
        rd_mux = g2_ths_q;
      end
      `AIG_ADDR_G2_DUR: begin
        rd_mux = g2_dur_q;
      end
      default: begin
        rd_mux = `AIG_RST_BYTE;
      end
    endcase
  end

  // Read data is captured with the strobe, so the host sees the status as it
  // stood before the clearing read took effect.
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      reg_rdata_q  <= `AIG_RST_BYTE;
      reg_rvalid_q <= 1'b0;
    end else begin
      reg_rvalid_q <= reg_rd;
      if (reg_rd) begin
        reg_rdata_q <= rd_mux;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  // Outputs are re-registered so every pin comes straight from a flop; this
  // costs one cycle of latency after the generator status updates.
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      fifo_mode_q    <= 3'h0;
      fifo_level_q   <= 5'h00;
      fifo_trigger_q <= 1'b0;
      int1_q         <= 1'b0;
      int2_q         <= 1'b0;
    end else begin
      fifo_mode_q    <= fifo_ctrl_q[7:5];
      fifo_level_q   <= fifo_ctrl_q[4:0];                              // see R19
      fifo_trigger_q <= g1_stat[`AIG_STAT_ACTIVE];                     // see R18
      int1_q         <= g1_stat[`AIG_STAT_ACTIVE];                     // see R21
      int2_q         <= g2_stat[`AIG_STAT_ACTIVE];                     // see R21
    end
  end

endmodule // aig_status_top

`default_nettype wire

/* aig_status_chk.sv */
// Purpose: Concurrent checks on the ports of the event and FIFO status block.
// Assumes: One clock domain; reset is asynchronous and active high.
// Notes: Interrupt timing allows one cycle of slack after a sample or a read.
`timescale 1ns/10ps
`default_nettype none

module aig_status_chk #(
  parameter CW = 6
) (
  // Clock and reset.
  input wire logic          ref_clk,
  input wire logic          reset,
  // Register port.
  input wire logic [7:0]    reg_addr,
  input wire logic          reg_wr,
  input wire logic [7:0]    reg_wdata,
  input wire logic          reg_rd,
  input wire logic [7:0]    reg_rdata_q,
  input wire logic          reg_rvalid_q,
  // Samples and FIFO.
  input wire logic          sample_valid,
  input wire logic [CW-1:0] fifo_count,
  input wire logic          fifo_full,
  input wire logic [2:0]    fifo_mode_q,
  input wire logic [4:0]    fifo_level_q,
  input wire logic          fifo_trigger_q,
  input wire logic          int1_q,
  input wire logic          int2_q
);
  // Low bits of the count, split out so $past sees a plain signal.
  wire logic [4:0] cnt_lo = fifo_count[4:0];
  wire logic       fst_rd = reg_rd && (reg_addr == 8'h2F);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  property p_rv; reg_rd |=> reg_rvalid_q; endproperty
  a_rv: assert property (p_rv) else $error("read valid missing");
  property p_nrv; !reg_rd |=> !reg_rvalid_q && $stable(reg_rdata_q); endproperty
  a_nrv: assert property (p_nrv) else $error("read data moved without read");
  property p_fth; fst_rd |=> reg_rdata_q[7] == ($past(fifo_count) >= fifo_level_q);
  endproperty
  a_fth: assert property (p_fth) else $error("threshold status wrong");
  property p_ovr; fst_rd |=> reg_rdata_q[6:5] == {$past(fifo_full), $past(fifo_count) == 0};
  endproperty
  a_ovr: assert property (p_ovr) else $error("full or empty status wrong");
  property p_lvl; fst_rd |=> reg_rdata_q[4:0] == $past(cnt_lo); endproperty
  a_lvl: assert property (p_lvl) else $error("fill level wrong");
  property p_ctl; reg_wr && reg_addr == 8'h2E |->
    ##2 {fifo_mode_q, fifo_level_q} == $past(reg_wdata, 2);
  endproperty
  a_ctl: assert property (p_ctl) else $error("FIFO control not taken");
  property p_trg; fifo_trigger_q == int1_q; endproperty
  a_trg: assert property (p_trg) else $error("FIFO trigger differs from generator one");
  property p_unm; reg_rd && reg_addr == 8'h00 |=> reg_rdata_q == 8'h00; endproperty
  a_unm: assert property (p_unm) else $error("unmapped read not zero");
  property p_i1; $changed(int1_q) |-> $past(sample_valid) || $past(sample_valid, 2)
    || $past(reg_rd, 2) || $past(reg_rd, 3); endproperty
  a_i1: assert property (p_i1) else $error("request one moved off sample");
  property p_i2; $changed(int2_q) |-> $past(sample_valid) || $past(sample_valid, 2)
    || $past(reg_rd, 2) || $past(reg_rd, 3); endproperty
  a_i2: assert property (p_i2) else $error("request two moved off sample");
endmodule // aig_status_chk

bind aig_status_top aig_status_chk #(.CW(CW)) aig_status_chk_i (
  .ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr), .reg_wr(reg_wr),
  .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
  .reg_rvalid_q(reg_rvalid_q), .sample_valid(sample_valid), .fifo_count(fifo_count),
  .fifo_full(fifo_full), .fifo_mode_q(fifo_mode_q), .fifo_level_q(fifo_level_q),
  .fifo_trigger_q(fifo_trigger_q), .int1_q(int1_q), .int2_q(int2_q));
`default_nettype wire

/* aig_sensor_model.sv */
// Purpose: Sensor front end and sample store seen from the status block.
// Assumes: One sample every eight clocks while run is high.
// Notes: Sample buses carry inverted data outside the valid pulse.
`timescale 1ns/10ps
`default_nettype none

module aig_sensor_model (
  // Clock and reset.
  input  wire logic        ref_clk,
  input  wire logic        reset,
  // Settings from the bench.
  input  wire logic        run,
  input  wire logic [15:0] x_val,
  input  wire logic [15:0] y_val,
  input  wire logic [15:0] z_val,
  input  wire logic [5:0]  count_val,
  // Towards the block.
  output logic             sample_valid,
  output logic [15:0]      x_sample,
  output logic [15:0]      y_sample,
  output logic [15:0]      z_sample,
  output logic [5:0]       fifo_count,
  output logic             fifo_full
);
  logic [2:0] div_q;
  // Stale values would hide a block that samples off the pulse, so they are inverted.
  assign x_sample = sample_valid ? x_val : ~x_val;
  assign y_sample = sample_valid ? y_val : ~y_val;
  assign z_sample = sample_valid ? z_val : ~z_val;
  // Output data rate divider and store occupancy.
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      div_q        <= 3'h0;
      sample_valid <= 1'b0;
      fifo_count   <= 6'h00;
      fifo_full    <= 1'b0;
    end else begin
      div_q        <= div_q + 3'h1;
      sample_valid <= run && (div_q == 3'h7);
      fifo_count   <= count_val;
      fifo_full    <= (count_val == 6'h20);
    end
  end
endmodule // aig_sensor_model
`default_nettype wire

/* tb_aig_status_top.sv */
// Purpose: Register-level tests of FIFO status and both interrupt generators.
// Assumes: Inputs change 1 ns after the rising edge.
// Notes: Expected values come from the register layouts, not from the design.
`timescale 1ns/10ps
`default_nettype none

module tb_aig_status_top;
  logic ref_clk = 1'b0, reset = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, run = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata_q;
  logic reg_rvalid_q, sample_valid, fifo_full, fifo_trigger_q, int1_q, int2_q;
  logic [15:0] x_val = 16'h0000, y_val = 16'h0000, x_sample, y_sample, z_sample;
  logic [5:0] count_val = 6'h00, fifo_count;
  logic [2:0] fifo_mode_q;
  logic [4:0] fifo_level_q;
  logic [7:0] rw_a [10] = '{8'h26, 8'h2E, 8'h30, 8'h32, 8'h33, 8'h34, 8'h35, 8'h36, 8'h38, 8'h39};
  logic [5:0] cnts [6] = '{6'h00, 6'h05, 6'h0F, 6'h10, 6'h1F, 6'h20};
  int miscompares = 0, num_checks = 0;

  // Clock at 200 MHz.
  always #2.5 ref_clk = ~ref_clk;

  aig_status_top aig_status_top_i (.ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
    .reg_rvalid_q(reg_rvalid_q), .sample_valid(sample_valid), .x_sample(x_sample),
    .y_sample(y_sample), .z_sample(z_sample), .fifo_count(fifo_count),
    .fifo_full(fifo_full), .fifo_mode_q(fifo_mode_q), .fifo_level_q(fifo_level_q),
    .fifo_trigger_q(fifo_trigger_q), .int1_q(int1_q), .int2_q(int2_q));
  aig_sensor_model aig_sensor_model_i (.ref_clk(ref_clk), .reset(reset), .run(run),
    .x_val(x_val), .y_val(y_val), .z_val(16'h0000), .count_val(count_val),
    .sample_valid(sample_valid), .x_sample(x_sample), .y_sample(y_sample),
    .z_sample(z_sample), .fifo_count(fifo_count), .fifo_full(fifo_full));

  // Prints the counts and the verdict, then stops.
  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One-cycle write strobe.
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge ref_clk) #1;
    reg_addr = a; reg_wdata = v; reg_wr = 1'b1;
    @(posedge ref_clk) #1;
    reg_wr = 1'b0;
  endtask

  // One-cycle read strobe, then a bounded wait for the answer.
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    int i;
    @(posedge ref_clk) #1;
    reg_addr = a; reg_rd = 1'b1;
    @(posedge ref_clk) #1;
    reg_rd = 1'b0;
    for (i = 0; i < 4 && reg_rvalid_q !== 1'b1; i++) @(posedge ref_clk) #1;
    if (i == 4) begin
      miscompares++;
      end_sim();
    end else begin
      check($sformatf("reg %h", a), reg_rdata_q, exp);
    end
  endtask

  // Counts sample pulses under a bound, then lets the requests settle.
  task automatic wait_samples(input int n);
    int k, i;
    k = 0;
    for (i = 0; i < 40 * n && k < n; i++) begin
      @(posedge ref_clk) #1;
      if (sample_valid === 1'b1) k++;
    end
    if (k < n) begin
      miscompares++;
      end_sim();
    end else begin
      repeat (3) @(posedge ref_clk);
      #1;
    end
  endtask

  // Main sequence.
  initial begin
    repeat (3) @(posedge ref_clk);
    #1 reset = 1'b0;
    foreach (rw_a[i]) rdc(rw_a[i], 8'h00);
    rdc(8'h31, 8'h00);
    rdc(8'h2F, 8'hA0);
    foreach (rw_a[i]) begin
      wr(rw_a[i], 8'hA5 ^ rw_a[i]);
      rdc(rw_a[i], 8'hA5 ^ rw_a[i]);
      wr(rw_a[i], 8'h00);
    end
    wr(8'h31, 8'hFF); wr(8'h37, 8'hFF); wr(8'h2F, 8'hFF); wr(8'h00, 8'hFF);
    rdc(8'h31, 8'h00); rdc(8'h37, 8'h00); rdc(8'h2F, 8'hA0); rdc(8'h00, 8'h00);
    // FIFO status around a threshold of 16.
    wr(8'h2E, 8'h10);
    foreach (cnts[i]) begin
      count_val = cnts[i];
      repeat (2) @(posedge ref_clk);
      rdc(8'h2F, {cnts[i] >= 6'h10, cnts[i] == 6'h20, cnts[i] == 6'h00, cnts[i][4:0]});
    end
    // Generator one, X high with OR, then AND with Y high.
    wr(8'h32, 8'h01); wr(8'h30, 8'h02); x_val = 16'h0100; run = 1'b1;
    wait_samples(1);
    rdc(8'h31, 8'h42);
    check("int1", {7'h00, int1_q}, 8'h01);
    wr(8'h33, 8'h01); wr(8'h30, 8'h8A);
    wait_samples(2);
    rdc(8'h31, 8'h00);
    y_val = 16'h0100;
    wait_samples(2);
    rdc(8'h31, 8'h4A);
    // Duration of three samples.
    y_val = 16'h0000; x_val = 16'h0000; wr(8'h30, 8'h02);
    wait_samples(1);
    wr(8'h35, 8'h03); x_val = 16'h0100;
    wait_samples(2);
    rdc(8'h31, 8'h00);
    wait_samples(3);
    rdc(8'h31, 8'h42);
    // Latched request holds after the condition goes, until the status read.
    wr(8'h35, 8'h00); wr(8'h26, 8'h04);
    wait_samples(1);
    x_val = 16'h0000;
    wait_samples(2);
    rdc(8'h31, 8'h42);
    rdc(8'h31, 8'h00);
    repeat (3) @(posedge ref_clk);
    check("int1 cleared", {7'h00, int1_q}, 8'h00);
    // Generator two in six-direction mode on negative X.
    wr(8'h26, 8'h00); wr(8'h30, 8'h00); wr(8'h38, 8'h01); wr(8'h36, 8'h41);
    x_val = 16'hFF00;
    wait_samples(1);
    rdc(8'h37, 8'h41);
    check("int2", {7'h00, int2_q}, 8'h01);
    wr(8'h36, 8'h42);
    wait_samples(2);
    rdc(8'h37, 8'h00);
    // Wait function holds the active bit for two samples after the event goes.
    wr(8'h39, 8'h82); wr(8'h36, 8'h41); wait_samples(4);
    x_val = 16'h0000; wait_samples(2); rdc(8'h37, 8'h40);
    wait_samples(1); rdc(8'h37, 8'h00);
    // Decrement mode keeps partial duration progress over one quiet sample.
    wr(8'h26, 8'h20); wr(8'h36, 8'h01); wait_samples(2);
    x_val = 16'hFF00; wait_samples(1);
    x_val = 16'h0000; wait_samples(2); rdc(8'h37, 8'h41);
    end_sim();
  end
endmodule // tb_aig_status_top
`default_nettype wire
